//--- include/tcc_pkg.sv
// constants, register map and field layouts of the 16-bit capture/compare timer
// assumes an APB slave with 32-bit data, one register per aligned word
//
// Notes on behaviour
// - capture irq enable gates either capture flag
// - compare irq enable gates either compare flag
// - overflow irq enable gates overflow flag
// - force two copies level two to pin two
// - force one copies level one to pin one
// - level two to pin two on match two in normal mode; to pin one in pulse/pwm
// - capture edge one: 0 falling, 1 rising
// - level one to pin one on match one
// - pin enable one only gates pin one drive
// - pin enable two only gates pin two drive
// - single pulse: capture edge triggers pulse one
// - pwm: width from compare one, period two
// - clock select: /4, /2, /8, external pin
// - no external pin: external select halts counter
// - capture edge two: 0 falling, 1 rising
// - external clock edge: 0 falling, 1 rising
// - capture flag one: capture or pwm period
// - compare flag one on match one in normal mode only, read-sequence clear
// - overflow flag on wrap, counter low clears
// - capture flag two, read-sequence clear
// - compare flag two, read-sequence clear
// - capture loads counter into capture pair
// - pwm and single pulse both set: pwm
// - high byte write suspends compare until low
package tcc_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_CTRL_TWO = 6'h01;
    localparam logic [5:0] IDX_CTRL_ONE = 6'h02;
    localparam logic [5:0] IDX_FLAGS = 6'h03;
    localparam logic [5:0] IDX_CAP_ONE_HI = 6'h04;
    localparam logic [5:0] IDX_CAP_ONE_LO = 6'h05;
    localparam logic [5:0] IDX_CMP_ONE_HI = 6'h06;
    localparam logic [5:0] IDX_CMP_ONE_LO = 6'h07;
    localparam logic [5:0] IDX_CNT_HI = 6'h08;
    localparam logic [5:0] IDX_CNT_LO = 6'h09;
    localparam logic [5:0] IDX_ALT_CNT_HI = 6'h0A;
    localparam logic [5:0] IDX_ALT_CNT_LO = 6'h0B;
    localparam logic [5:0] IDX_CAP_TWO_HI = 6'h0C;
    localparam logic [5:0] IDX_CAP_TWO_LO = 6'h0D;
    localparam logic [5:0] IDX_CMP_TWO_HI = 6'h0E;
    localparam logic [5:0] IDX_CMP_TWO_LO = 6'h0F;

    // reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_CMP_HI = 8'h80;
    localparam logic [7:0] RST_CMP_LO = 8'h00;
    localparam logic [15:0] RST_COUNT = 16'hFFFC;
    localparam logic [15:0] COUNT_TOP = 16'hFFFF;

    // clock select codes and prescaler masks
    localparam logic [1:0] CLK_DIV4 = 2'h0;
    localparam logic [1:0] CLK_DIV2 = 2'h1;
    localparam logic [1:0] CLK_DIV8 = 2'h2;
    localparam logic [1:0] CLK_EXT = 2'h3;
    localparam logic [2:0] MASK_DIV2 = 3'h1;
    localparam logic [2:0] MASK_DIV4 = 3'h3;
    localparam logic [2:0] MASK_DIV8 = 3'h7;

    // edge source slots of the edge detector bank
    localparam int SRC_CAP_ONE = 0;
    localparam int SRC_CAP_TWO = 1;
    localparam int SRC_EXT = 2;
    localparam int SRC_COUNT = 3;

    typedef struct packed {
        logic capture_irq_enable;
        logic compare_irq_enable;
        logic overflow_irq_enable;
        logic force_level_two;
        logic force_level_one;
        logic output_level_two;
        logic capture_edge_one;
        logic output_level_one;
    } tcc_ctrl_one_s;

    typedef struct packed {
        logic compare_pin_one_enable;
        logic compare_pin_two_enable;
        logic single_pulse_mode;
        logic pwm_mode;
        logic [1:0] clock_select;
        logic capture_edge_two;
        logic ext_clock_edge;
    } tcc_ctrl_two_s;

    typedef struct packed {
        logic capture_flag_one;
        logic compare_flag_one;
        logic overflow_flag;
        logic capture_flag_two;
        logic compare_flag_two;
        logic [2:0] reserved;
    } tcc_flags_s;

endpackage

//--- core/tcc_edge_detect.sv
// selected-edge detector for one synchronous pin
// assumes the pin is already synchronous to pclk
`timescale 1ns/10ps
module tcc_edge_detect (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pin and edge choice
    input wire logic pin,
    input wire logic rising_sel,
    // result
    output logic hit
);
    logic prev_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= pin;
        end
    end

    // 1 selects rising, 0 falling
    assign hit = (prev_reg != pin) && (pin == rising_sel);
endmodule

//--- core/tcc_timer.sv
// 16-bit free-running timer with two captures, two compares and APB registers
// assumes synchronous pins and an APB master on pclk
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/10ps
module tcc_timer #(
    parameter bit HAS_EXT_CLK = 1'b1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timer pins
    input wire logic capture_in_one,
    input wire logic capture_in_two,
    input wire logic ext_count_clock,
    output logic compare_out_one,
    output logic compare_out_one_oe,
    output logic compare_out_two,
    output logic compare_out_two_oe,
    // interrupt
    output logic timer_irq
);
    tcc_pkg::tcc_ctrl_one_s cr1_reg;
    tcc_pkg::tcc_ctrl_two_s cr2_reg;
    tcc_pkg::tcc_flags_s flags_reg;
    tcc_pkg::tcc_flags_s flags_next;
    logic [4:0] arm_reg;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_inc;
    logic [2:0] presc_reg;
    logic [15:0] cmp_one_reg;
    logic [15:0] cmp_two_reg;
    logic [15:0] cap_one_reg;
    logic [15:0] cap_two_reg;
    logic inhibit_one_reg;
    logic inhibit_two_reg;
    logic out_one_reg;
    logic out_two_reg;
    logic oe_one_reg;
    logic oe_two_reg;
    logic irq_reg;
    logic ready_reg;
    logic err_reg;
    logic [31:0] rdata_reg;

    // apb decode
    wire logic [5:0] idx = paddr[7:2];
    wire logic acc = psel && penable && ready_reg;
    wire logic wr = acc && pwrite;
    wire logic rd = acc && !pwrite;
    wire logic mapped = (idx >= tcc_pkg::IDX_CTRL_TWO) && (idx <= tcc_pkg::IDX_CMP_TWO_LO);

    function automatic logic touch(input logic [5:0] i, input logic [5:0] r, input logic a);
        return a && (i == r);
    endfunction

    function automatic logic [7:0] rd_mux(input logic [5:0] i, input tcc_pkg::tcc_ctrl_one_s c1,
            input tcc_pkg::tcc_ctrl_two_s c2, input tcc_pkg::tcc_flags_s f,
            input logic [15:0] k1, input logic [15:0] k2, input logic [15:0] m1,
            input logic [15:0] m2, input logic [15:0] n);
        logic [7:0] v;
        v = 8'h00;
        unique case (i)
            tcc_pkg::IDX_CTRL_TWO: v = c2;
            tcc_pkg::IDX_CTRL_ONE: v = c1;
            tcc_pkg::IDX_FLAGS: v = {f[7:3], 3'h0};
            tcc_pkg::IDX_CAP_ONE_HI: v = k1[15:8];
            tcc_pkg::IDX_CAP_ONE_LO: v = k1[7:0];
            tcc_pkg::IDX_CMP_ONE_HI: v = m1[15:8];
            tcc_pkg::IDX_CMP_ONE_LO: v = m1[7:0];
            tcc_pkg::IDX_CNT_HI: v = n[15:8];
            tcc_pkg::IDX_CNT_LO: v = n[7:0];
            tcc_pkg::IDX_ALT_CNT_HI: v = n[15:8];
            tcc_pkg::IDX_ALT_CNT_LO: v = n[7:0];
            tcc_pkg::IDX_CAP_TWO_HI: v = k2[15:8];
            tcc_pkg::IDX_CAP_TWO_LO: v = k2[7:0];
            tcc_pkg::IDX_CMP_TWO_HI: v = m2[15:8];
            tcc_pkg::IDX_CMP_TWO_LO: v = m2[7:0];
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    wire logic [7:0] rd_byte = rd_mux(idx, cr1_reg, cr2_reg, flags_reg, cap_one_reg, cap_two_reg,
        cmp_one_reg, cmp_two_reg, cnt_reg);

    // edge detector bank: capture one, capture two, external clock
    wire logic [tcc_pkg::SRC_COUNT-1:0] src_pin = {ext_count_clock, capture_in_two, capture_in_one};
    wire logic [tcc_pkg::SRC_COUNT-1:0] src_sel = {cr2_reg.ext_clock_edge,
        cr2_reg.capture_edge_two, cr1_reg.capture_edge_one};
    logic [tcc_pkg::SRC_COUNT-1:0] src_hit;

    genvar g;
    generate
        for (g = 0; g < tcc_pkg::SRC_COUNT; g++) begin : g_edge
            tcc_edge_detect u_edge (
                .pclk(pclk),
                .presetn(presetn),
                .pin(src_pin[g]),
                .rising_sel(src_sel[g]),
                .hit(src_hit[g])
            );
        end
    endgenerate

    // mode decode
    // pwm wins
    wire logic pwm_on = cr2_reg.pwm_mode;
    wire logic pulse_on = cr2_reg.single_pulse_mode && !cr2_reg.pwm_mode;
    wire logic normal_on = !pwm_on && !pulse_on;

    // prescaler and counter tick
    // prescaler mask
    wire logic [2:0] presc_mask = (cr2_reg.clock_select == tcc_pkg::CLK_DIV2) ? tcc_pkg::MASK_DIV2 :
        (cr2_reg.clock_select == tcc_pkg::CLK_DIV8) ? tcc_pkg::MASK_DIV8 : tcc_pkg::MASK_DIV4;
    wire logic ext_sel = (cr2_reg.clock_select == tcc_pkg::CLK_EXT);
    wire logic ext_tick = HAS_EXT_CLK && src_hit[tcc_pkg::SRC_EXT];
    wire logic tick = ext_sel ? ext_tick : ((presc_reg & presc_mask) == presc_mask);
    assign cnt_inc = cnt_reg + 16'h0001;

    // compare matches, suspended after a high byte write
    // compare suspend
    wire logic match_one = tick && !inhibit_one_reg && (cnt_inc == cmp_one_reg);
    wire logic match_two = tick && !inhibit_two_reg && (cnt_inc == cmp_two_reg);
    wire logic pulse_trig = pulse_on && src_hit[tcc_pkg::SRC_CAP_ONE];
    wire logic cap_one_hit = normal_on && src_hit[tcc_pkg::SRC_CAP_ONE];
    wire logic cap_two_hit = src_hit[tcc_pkg::SRC_CAP_TWO];
    wire logic period_end = pwm_on && match_two;
    wire logic cnt_clear = touch(idx, tcc_pkg::IDX_CNT_LO, wr) ||
        touch(idx, tcc_pkg::IDX_ALT_CNT_LO, wr) || period_end || pulse_trig;
    wire logic wrap = tick && !cnt_clear && (cnt_reg == tcc_pkg::COUNT_TOP);

    // flag set and read-sequence clear
    wire logic set_capture_flag_one = cap_one_hit || period_end;
    wire logic set_compare_flag_one = match_one && normal_on;
    wire logic set_tof = wrap;
    wire logic set_capture_flag_two = cap_two_hit;
    wire logic set_compare_flag_two = match_two && !pwm_on;
    wire logic [4:0] low_acc = {touch(idx, tcc_pkg::IDX_CAP_ONE_LO, acc),
        touch(idx, tcc_pkg::IDX_CMP_ONE_LO, acc), touch(idx, tcc_pkg::IDX_CNT_LO, acc),
        touch(idx, tcc_pkg::IDX_CAP_TWO_LO, acc), touch(idx, tcc_pkg::IDX_CMP_TWO_LO, acc)};
    wire logic [4:0] clr = arm_reg & low_acc;
    wire logic [4:0] set_vec = {set_capture_flag_one, set_compare_flag_one, set_tof, set_capture_flag_two, set_compare_flag_two};
    wire logic flags_rd = touch(idx, tcc_pkg::IDX_FLAGS, rd);

    assign flags_next = {set_vec | (flags_reg[7:3] & ~clr), 3'h0};

    wire logic irq_next =
        (cr1_reg.capture_irq_enable && (flags_reg.capture_flag_one || flags_reg.capture_flag_two)) ||
        (cr1_reg.compare_irq_enable && (flags_reg.compare_flag_one || flags_reg.compare_flag_two)) ||
        (cr1_reg.overflow_irq_enable && flags_reg.overflow_flag);

    // compare pin one and two levels
    // pin one
    wire logic out_one_next = cr1_reg.force_level_one ? cr1_reg.output_level_one :
        (period_end || pulse_trig) ? cr1_reg.output_level_two :
        match_one ? cr1_reg.output_level_one : out_one_reg;
    wire logic out_two_next = cr1_reg.force_level_two ? cr1_reg.output_level_two :
        (match_two && normal_on) ? cr1_reg.output_level_two : out_two_reg;

    // apb handshake: one wait state, read data registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ready_reg <= psel && penable && !ready_reg;
            err_reg <= psel && penable && !ready_reg && !mapped;
            rdata_reg <= {24'h00_0000, rd_byte};
        end
    end

    // control and compare registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cr1_reg <= tcc_pkg::RST_CTRL;
            cr2_reg <= tcc_pkg::RST_CTRL;
            cmp_one_reg <= {tcc_pkg::RST_CMP_HI, tcc_pkg::RST_CMP_LO};
            cmp_two_reg <= {tcc_pkg::RST_CMP_HI, tcc_pkg::RST_CMP_LO};
        end else begin
            if (touch(idx, tcc_pkg::IDX_CTRL_ONE, wr)) begin
                cr1_reg <= pwdata[7:0];
            end
            if (touch(idx, tcc_pkg::IDX_CTRL_TWO, wr)) begin
                cr2_reg <= pwdata[7:0];
            end
            if (touch(idx, tcc_pkg::IDX_CMP_ONE_HI, wr)) begin
                cmp_one_reg[15:8] <= pwdata[7:0];
            end
            if (touch(idx, tcc_pkg::IDX_CMP_ONE_LO, wr)) begin
                cmp_one_reg[7:0] <= pwdata[7:0];
            end
            if (touch(idx, tcc_pkg::IDX_CMP_TWO_HI, wr)) begin
                cmp_two_reg[15:8] <= pwdata[7:0];
            end
            if (touch(idx, tcc_pkg::IDX_CMP_TWO_LO, wr)) begin
                cmp_two_reg[7:0] <= pwdata[7:0];
            end
        end
    end

    // compare suspend after high byte write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inhibit_one_reg <= 1'b0;
            inhibit_two_reg <= 1'b0;
        end else begin
            if (touch(idx, tcc_pkg::IDX_CMP_ONE_HI, wr)) begin
                inhibit_one_reg <= 1'b1;
            end else if (touch(idx, tcc_pkg::IDX_CMP_ONE_LO, wr)) begin
                inhibit_one_reg <= 1'b0;
            end
            if (touch(idx, tcc_pkg::IDX_CMP_TWO_HI, wr)) begin
                inhibit_two_reg <= 1'b1;
            end else if (touch(idx, tcc_pkg::IDX_CMP_TWO_LO, wr)) begin
                inhibit_two_reg <= 1'b0;
            end
        end
    end

    // prescaler and counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_reg <= 3'h0;
            cnt_reg <= tcc_pkg::RST_COUNT;
        end else begin
            presc_reg <= presc_reg + 3'h1;
            if (cnt_clear) begin
                cnt_reg <= tcc_pkg::RST_COUNT;
            end else if (tick) begin
                cnt_reg <= cnt_inc;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_one_reg <= 16'h0000;
            cap_two_reg <= 16'h0000;
        end else begin
            if (cap_one_hit) begin
                cap_one_reg <= cnt_reg;
            end
            if (cap_two_hit) begin
                cap_two_reg <= cnt_reg;
            end
        end
    end

    // flags, read-sequence arming, interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= tcc_pkg::RST_FLAGS;
            arm_reg <= 5'h00;
            irq_reg <= 1'b0;
        end else begin
            flags_reg <= flags_next;
            arm_reg <= flags_rd ? flags_reg[7:3] : (arm_reg & ~low_acc);
            irq_reg <= irq_next;
        end
    end

    // compare pins
    // enables only gate the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_one_reg <= 1'b0;
            out_two_reg <= 1'b0;
            oe_one_reg <= 1'b0;
            oe_two_reg <= 1'b0;
        end else begin
            out_one_reg <= out_one_next;
            out_two_reg <= out_two_next;
            oe_one_reg <= cr2_reg.compare_pin_one_enable;
            oe_two_reg <= cr2_reg.compare_pin_two_enable;
        end
    end

    assign prdata = rdata_reg;
    assign pready = ready_reg;
    assign pslverr = err_reg;
    assign compare_out_one = out_one_reg;
    assign compare_out_one_oe = oe_one_reg;
    assign compare_out_two = out_two_reg;
    assign compare_out_two_oe = oe_two_reg;
    assign timer_irq = irq_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_IRQ_CAPTURE: assert property (
        (cr1_reg.capture_irq_enable && flags_reg.capture_flag_two) |=> timer_irq)
        else $error("capture flag with enable did not raise irq");
    AST_IRQ_COMPARE: assert property (
        (cr1_reg.compare_irq_enable && flags_reg.compare_flag_one) |=> timer_irq)
        else $error("compare flag with enable did not raise irq");
    AST_IRQ_NONE: assert property (
        (cr1_reg[7:5] == 3'h0) |=> !timer_irq)
        else $error("irq raised with all enables clear");
    AST_FORCE_TWO: assert property (
        cr1_reg.force_level_two |=> (compare_out_two == $past(cr1_reg.output_level_two)))
        else $error("forced level two not on pin two");
    AST_MATCH_ONE: assert property (
        (match_one && normal_on && !cr1_reg.force_level_one)
        |=> (compare_out_one == $past(cr1_reg.output_level_one)) && flags_reg.compare_flag_one)
        else $error("match one did not drive level one or set flag");
    AST_WRAP: assert property (
        wrap |=> (cnt_reg == 16'h0000) && flags_reg.overflow_flag)
        else $error("wrap did not zero counter and set overflow");
    AST_CAPTURE_LOAD: assert property (
        cap_two_hit |=> (cap_two_reg == $past(cnt_reg)) && flags_reg.capture_flag_two)
        else $error("capture two did not load counter");
    AST_SUSPEND: assert property (
        touch(idx, tcc_pkg::IDX_CMP_ONE_HI, wr) |=> !match_one throughout
        (!touch(idx, tcc_pkg::IDX_CMP_ONE_LO, wr))[*2])
        else $error("compare one matched while suspended");
    AST_PWM_PERIOD: assert property (
        period_end |=> (cnt_reg == tcc_pkg::RST_COUNT) && flags_reg.capture_flag_one
        && !flags_reg.compare_flag_two)
        else $error("pwm period end mishandled");
    AST_DIV2: assert property (
        (cr2_reg.clock_select == tcc_pkg::CLK_DIV2) && !cnt_clear && tick
        && $stable(cr2_reg) |=> !tick)
        else $error("divide by two ticked twice in a row");
    AST_CLEAR_SEQ: assert property (
        (clr[1] && !set_capture_flag_two) |=> !flags_reg.capture_flag_two)
        else $error("read sequence did not clear capture flag two");

    COV_PWM: cover property (period_end);
    COV_PULSE: cover property (pulse_trig ##[1:300] match_one);
    COV_FLAG_CLEAR: cover property (flags_rd ##[1:20] (clr != 5'h00));
    COV_UNMAPPED: cover property (pslverr && pready);
endmodule

//--- tb/tcc_pin_model.sv
// pin-side model: capture pins and the external count pin
// assumes pclk is the timer clock; pins change just after a rising edge
`timescale 1ns/10ps
module tcc_pin_model (
    // clock
    input wire logic pclk,
    // pins toward the timer
    output logic capture_in_one,
    output logic capture_in_two,
    output logic ext_count_clock
);
    initial begin
        capture_in_one = 1'b0;
        capture_in_two = 1'b0;
        ext_count_clock = 1'b0;
    end
    // levels held four cycles so every edge is seen
    task automatic set_caps(input logic a, input logic b);
        @(posedge pclk);
        capture_in_one <= a;
        capture_in_two <= b;
        repeat (4) @(posedge pclk);
    endtask
    // one period of the count pin, low again between pulses
    task automatic ext_pulse();
        @(posedge pclk);
        ext_count_clock <= 1'b1;
        repeat (4) @(posedge pclk);
        ext_count_clock <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
endmodule

//--- tb/tcc_timer_bench.sv
// self-checking bench of the timer: apb register tasks and pin checks
// assumes the pin model drives the capture and count pins
`timescale 1ns/10ps
module tcc_timer_bench;
    logic pclk, presetn, psel, penable, pwrite, err;
    logic [7:0] paddr, rd;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, out1, oe1, out2, oe2, irq;
    wire cap1, cap2, ext;
    int bad_count, n_tests, cycles;

    tcc_pin_model tcc_pin_model_inst (.pclk(pclk), .capture_in_one(cap1),
        .capture_in_two(cap2), .ext_count_clock(ext));
    tcc_timer tcc_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_in_one(cap1),
        .capture_in_two(cap2), .ext_count_clock(ext), .compare_out_one(out1),
        .compare_out_one_oe(oe1), .compare_out_two(out2), .compare_out_two_oe(oe2),
        .timer_irq(irq));

    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask
    task automatic rdc(string what, logic [5:0] idx, logic [7:0] msk, logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(what, exp, rd & msk);
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
        apb(1'b1, idx, wd);
    endtask
    // pin vector: out one, oe one, out two, oe two, irq
    task automatic pins(input string what, input logic [4:0] msk, input logic [4:0] exp);
        repeat (3) @(posedge pclk);
        chk(what, {3'h0, exp}, {3'h0, {out1, oe1, out2, oe2, irq} & msk});
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc("ctrl one", tcc_pkg::IDX_CTRL_ONE, 8'hFF, 8'h00);
        rdc("ctrl two", tcc_pkg::IDX_CTRL_TWO, 8'hFF, 8'h00);
        rdc("cmp one hi", tcc_pkg::IDX_CMP_ONE_HI, 8'hFF, 8'h80);
        rdc("cmp one lo", tcc_pkg::IDX_CMP_ONE_LO, 8'hFF, 8'h00);
        rdc("cmp two hi", tcc_pkg::IDX_CMP_TWO_HI, 8'hFF, 8'h80);
        wr(tcc_pkg::IDX_FLAGS, 8'hF8);
        // counter leaves reset at FFFC and wraps well before this read
        rdc("flags", tcc_pkg::IDX_FLAGS, 8'hFF, 8'h20);
        apb(1'b0, 6'h00, 8'h00);
        chk("unmapped err", 8'h01, {7'h00, err});
        $display("test reset done");
        wr(tcc_pkg::IDX_CTRL_TWO, 8'hC4);
        wr(tcc_pkg::IDX_CTRL_ONE, 8'h1D);
        pins("force high", 5'h1F, 5'b11110);
        wr(tcc_pkg::IDX_CTRL_TWO, 8'h04);
        pins("pins freed", 5'b01010, 5'b00000);
        wr(tcc_pkg::IDX_CTRL_TWO, 8'hC4);
        wr(tcc_pkg::IDX_CTRL_ONE, 8'h18);
        pins("force low", 5'h1F, 5'b01010);
        $display("test force done");
        wr(tcc_pkg::IDX_CMP_TWO_HI, 8'h00);
        wr(tcc_pkg::IDX_CMP_ONE_HI, 8'h00);
        wr(tcc_pkg::IDX_CMP_ONE_LO, 8'h10);
        wr(tcc_pkg::IDX_CTRL_ONE, 8'h65);
        wr(tcc_pkg::IDX_CNT_LO, 8'h00);
        repeat (60) @(posedge pclk);
        rdc("flags match one", tcc_pkg::IDX_FLAGS, 8'hFF, 8'h60);
        pins("match one", 5'h1F, 5'b11011);
        wr(tcc_pkg::IDX_CMP_TWO_LO, 8'h80);
        repeat (300) @(posedge pclk);
        rdc("flags match two", tcc_pkg::IDX_FLAGS, 8'hFF, 8'h68);
        pins("match two", 5'h1F, 5'b11111);
        apb(1'b0, tcc_pkg::IDX_ALT_CNT_LO, 8'h00);
        rdc("flags after alt", tcc_pkg::IDX_FLAGS, 8'h20, 8'h20);
        apb(1'b0, tcc_pkg::IDX_CNT_LO, 8'h00);
        apb(1'b0, tcc_pkg::IDX_CMP_ONE_LO, 8'h00);
        apb(1'b0, tcc_pkg::IDX_CMP_TWO_LO, 8'h00);
        rdc("flags cleared", tcc_pkg::IDX_FLAGS, 8'hFF, 8'h00);
        pins("irq low", 5'h01, 5'h00);
        $display("test compare done");
        wr(tcc_pkg::IDX_CTRL_ONE, 8'h82);
        wr(tcc_pkg::IDX_CNT_LO, 8'h00);
        repeat (20) @(posedge pclk);
        tcc_pin_model_inst.set_caps(1'b1, 1'b1);
        rdc("capture rise", tcc_pkg::IDX_FLAGS, 8'h90, 8'h80);
        tcc_pin_model_inst.set_caps(1'b0, 1'b0);
        rdc("capture fall", tcc_pkg::IDX_FLAGS, 8'h90, 8'h90);
        pins("capture irq", 5'h01, 5'h01);
        rdc("cap one hi", tcc_pkg::IDX_CAP_ONE_HI, 8'hFF, 8'h00);
        rdc("cap two hi", tcc_pkg::IDX_CAP_TWO_HI, 8'hFF, 8'h00);
        apb(1'b0, tcc_pkg::IDX_CAP_ONE_LO, 8'h00);
        apb(1'b0, tcc_pkg::IDX_CAP_TWO_LO, 8'h00);
        rdc("capture cleared", tcc_pkg::IDX_FLAGS, 8'h90, 8'h00);
        $display("test capture done");
        wr(tcc_pkg::IDX_CTRL_TWO, 8'hCD);
        wr(tcc_pkg::IDX_CNT_LO, 8'h00);
        repeat (3) tcc_pin_model_inst.ext_pulse();
        rdc("ext rising lo", tcc_pkg::IDX_CNT_LO, 8'hFF, 8'hFF);
        rdc("ext rising hi", tcc_pkg::IDX_CNT_HI, 8'hFF, 8'hFF);
        wr(tcc_pkg::IDX_CTRL_TWO, 8'hCC);
        tcc_pin_model_inst.ext_pulse();
        rdc("ext falling", tcc_pkg::IDX_CNT_LO, 8'hFF, 8'h00);
        $display("test external clock done");
        apb(1'b0, tcc_pkg::IDX_FLAGS, 8'h00);
        apb(1'b0, tcc_pkg::IDX_CMP_ONE_LO, 8'h00);
        wr(tcc_pkg::IDX_CTRL_ONE, 8'h01);
        wr(tcc_pkg::IDX_CTRL_TWO, 8'hF4);
        wr(tcc_pkg::IDX_CNT_LO, 8'h00);
        repeat (400) @(posedge pclk);
        rdc("pwm flags", tcc_pkg::IDX_FLAGS, 8'hC8, 8'h80);
        $display("test pwm done");
        // single pulse on a falling capture one edge, pin two off
        wr(tcc_pkg::IDX_CTRL_TWO, 8'hA4);
        apb(1'b0, tcc_pkg::IDX_FLAGS, 8'h00);
        apb(1'b0, tcc_pkg::IDX_CAP_ONE_LO, 8'h00);
        tcc_pin_model_inst.set_caps(1'b1, 1'b0);
        tcc_pin_model_inst.set_caps(1'b0, 1'b0);
        pins("pulse start", 5'h10, 5'h00);
        repeat (60) @(posedge pclk);
        pins("pulse end", 5'h10, 5'h10);
        rdc("pulse flags", tcc_pkg::IDX_FLAGS, 8'hC0, 8'h00);
        $display("test single pulse done");
        end_sim();
    end
endmodule
